// >>> core/lgpp_core.v
// Gateway station controller: primary election, polling, handover,
// frame buffering and local/foreign delivery decision.
// Assumes a response arrives for every command issued, and M is 2**AW.
`timescale 1ns/1ns
`include "lgpp_map.vh"
module lgpp_core #(
  parameter        M        = `LGPP_MAX_STATIONS,
  parameter        AW       = `LGPP_ADDR_W,
  parameter        LW       = `LGPP_COORD_W,
  parameter        NBUF     = `LGPP_GW_BUFS,
  parameter        SW       = `LGPP_SLOT_W,
  parameter        TW       = 34,
  parameter [63:0] ROT_CYC  = `LGPP_ROT_CYC,
  parameter [31:0] WD_CYC   = `LGPP_WD_CYC,
  parameter [31:0] PROP_CYC = `LGPP_PROP_CYC,
  parameter [31:0] E2E_CYC  = `LGPP_E2E_CYC
) (
  input  wire          sys_clk_i,
  input  wire          rst_n_i,
  input  wire [AW-1:0] self_addr_i,
  input  wire [LW-1:0] loop_l_i,
  input  wire [LW-1:0] loop_n_i,
  input  wire          loop_signal_i,
  output wire          cmd_valid_o,
  output wire [1:0]    cmd_kind_o,
  output wire [AW-1:0] cmd_addr_o,
  output wire [SW-1:0] cmd_slot_o,
  input  wire          rsp_valid_i,
  input  wire          rsp_present_i,
  input  wire          rsp_gateway_i,
  input  wire          rsp_traffic_i,
  input  wire          rsp_ack_i,
  input  wire          rsp_rnr_i,
  input  wire [LW-1:0] rsp_floop_l_i,
  input  wire [LW-1:0] rsp_floop_n_i,
  input  wire          rsp_floop_ok_i,
  input  wire          grant_i,
  input  wire          grant_traffic_i,
  input  wire          frm_valid_i,
  output wire          frm_ready_o,
  input  wire [LW-1:0] frm_dst_l_i,
  input  wire [LW-1:0] frm_dst_n_i,
  input  wire [AW-1:0] frm_dst_s_i,
  output wire          xfer_valid_o,
  output wire [LW-1:0] xfer_dst_l_o,
  output wire [LW-1:0] xfer_dst_n_o,
  output wire [AW-1:0] xfer_dst_s_o,
  output wire          reroute_o,
  output wire          undeliv_o,
  output wire [AW-1:0] ret_dst_s_o,
  input  wire          msg_sent_i,
  input  wire          e2e_ack_i,
  output wire          not_delivered_o,
  output wire          trouble_o,
  output wire [1:0]    trouble_code_o,
  output wire          del_valid_o,
  output wire [M-1:0]  del_mask_o,
  output wire          primary_o
);
  localparam [3:0] ST_SEC   = 4'h0;
  localparam [3:0] ST_STAG  = 4'h1;
  localparam [3:0] ST_POLL  = 4'h2;
  localparam [3:0] ST_WAIT  = 4'h3;
  localparam [3:0] ST_ADV   = 4'h4;
  localparam [3:0] ST_FWD   = 4'h5;
  localparam [3:0] ST_FWAIT = 4'h6;
  localparam [3:0] ST_OFFER = 4'h7;
  localparam [3:0] ST_OWAIT = 4'h8;
  localparam [3:0] ST_CMP   = 4'h9;
  localparam [1:0] TRY_LAST = `LGPP_TRY_LIMIT - 2'h1;
  localparam [1:0] SEQ_LAST = `LGPP_SEQ_LIMIT - 2'h1;

  ////////////////////////////////////////////////////////////////////////
  // Functions
  // Lowest set bit of a buffer vector
  function [SW-1:0] first_idx;
    input [NBUF-1:0] v;
    integer          k;
    begin
      first_idx = {SW{1'b0}};
      for (k = NBUF - 1; k >= 0; k = k - 1) begin
        if (v[k])
          first_idx = k[SW-1:0];
      end
    end
  endfunction

  // Next listed address above from, wrapping modulo M; self if none
  function [AW-1:0] next_occ;
    input [M-1:0]  occ;
    input [AW-1:0] from;
    input [AW-1:0] self;
    integer        k;
    reg   [AW-1:0] a;
    reg            hit;
    begin
      next_occ = self;
      hit = 1'b0;
      a = from;
      for (k = 1; k < M; k = k + 1) begin
        a = a + 1'b1;
        if (!hit && occ[a]) begin
          next_occ = a;
          hit = 1'b1;
        end
      end
    end
  endfunction

  // Destination minus local coordinate is zero
  function dzero;
    input [LW-1:0] d;
    input [LW-1:0] c;
    reg   [LW-1:0] df;
    begin
      df = d - c;
      dzero = (df == {LW{1'b0}});
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State
  reg  [3:0]    state_q;
  reg           init_q;
  reg  [AW-1:0] self_q;
  reg           primary_q;
  reg           full_q;
  reg           drain_q;
  reg           rot_done_q;
  reg  [1:0]    seq_cnt_q;
  reg  [AW-1:0] poll_addr_q;
  reg  [M-1:0]  occ_q;
  reg  [M-1:0]  gw_q;
  reg  [M-1:0]  trf_q;
  reg  [M-1:0]  fok_q;
  reg  [M-1:0]  prev_occ_q;
  reg  [M-1:0]  prev_fok_q;
  reg  [LW-1:0] fl_l_q [0:M-1];
  reg  [LW-1:0] fl_n_q [0:M-1];
  reg  [NBUF-1:0] bv_q;
  reg  [NBUF-1:0] bh_q;
  reg  [AW-1:0] bs_q [0:NBUF-1];
  reg  [1:0]    br_q [0:NBUF-1];
  reg  [SW-1:0] cur_q;
  reg           wd_start_q;
  reg           stag_start_q;
  reg           rot_start_q;
  reg           rot_stop_q;
  reg           cmd_valid_q;
  reg  [1:0]    cmd_kind_q;
  reg  [AW-1:0] cmd_addr_q;
  reg  [SW-1:0] cmd_slot_q;
  reg           xfer_valid_q;
  reg  [LW-1:0] xfer_l_q;
  reg  [LW-1:0] xfer_n_q;
  reg  [AW-1:0] xfer_s_q;
  reg           reroute_q;
  reg           undeliv_q;
  reg  [AW-1:0] ret_s_q;
  reg           trouble_q;
  reg  [1:0]    trouble_code_q;
  reg           del_valid_q;
  reg  [M-1:0]  del_mask_q;
  reg  [AW-1:0] adv_addr;
  wire          adv_wrap;
  wire          sig_s;
  wire          wd_exp;
  wire          stag_exp;
  wire          rot_exp;
  wire          is_local;
  wire [NBUF-1:0] fwd_vec;
  wire          fwd_rdy;
  wire [SW-1:0] free_slot;
  wire [M-1:0]  deleted;
  wire [TW-1:0] stag_load;
  wire [AW-1:0] self_m1;

  ////////////////////////////////////////////////////////////////////////
  // Loop activity and timers
  lgpp_sync u_sig (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (loop_signal_i),
    .sync_o    (sig_s)
  );

  // Watchdog: restarted by any loop activity while secondary
  lgpp_timer #(.W(TW)) u_wd (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (wd_start_q),
    .stop_i    (rot_start_q),
    .load_i    (WD_CYC[TW-1:0]),
    .expire_o  (wd_exp)
  );

  // Stagger grows one propagation delay per address above one
  assign self_m1   = self_q - 1'b1;
  assign stag_load = (self_q == {AW{1'b0}}) ? {TW{1'b0}} :
                     {{(TW-AW){1'b0}}, self_m1} * PROP_CYC[TW-1:0];
  lgpp_timer #(.W(TW)) u_stag (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (stag_start_q),
    .stop_i    (wd_start_q),
    .load_i    (stag_load),
    .expire_o  (stag_exp)
  );

  // Rotation timer: one run per primary tenure
  lgpp_timer #(.W(TW)) u_rot (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (rot_start_q),
    .stop_i    (rot_stop_q),
    .load_i    (ROT_CYC[TW-1:0]),
    .expire_o  (rot_exp)
  );

  // Originator wait for end-to-end answer or returned message
  lgpp_timer #(.W(TW)) u_e2e (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (msg_sent_i),
    .stop_i    (e2e_ack_i),
    .load_i    (E2E_CYC[TW-1:0]),
    .expire_o  (not_delivered_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode
  assign is_local  = dzero(frm_dst_l_i, loop_l_i) &
                     dzero(frm_dst_n_i, loop_n_i);
  assign fwd_vec   = bv_q & ~bh_q;
  assign fwd_rdy   = |fwd_vec;
  assign free_slot = first_idx(~bv_q);
  assign frm_ready_o = init_q & (~is_local | ~&bv_q);
  assign deleted   = (prev_occ_q & ~occ_q) | (prev_fok_q & ~fok_q);

  // Next poll address: every address, or only listed ones
  always @* begin
    if (full_q)
      adv_addr = poll_addr_q + 1'b1;
    else
      adv_addr = next_occ(occ_q, poll_addr_q, self_q);
  end
  assign adv_wrap = full_q ? (adv_addr == self_q) :
                    (adv_addr <= poll_addr_q);

  ////////////////////////////////////////////////////////////////////////
  // Main sequencer, lists and frame buffers
  always @(posedge sys_clk_i) begin : seq
    if (!rst_n_i) begin
      state_q      <= ST_SEC;
      init_q       <= 1'b0;
      self_q       <= {AW{1'b0}};
      primary_q    <= 1'b0;
      full_q       <= 1'b0;
      drain_q      <= 1'b0;
      rot_done_q   <= 1'b0;
      seq_cnt_q    <= 2'h0;
      poll_addr_q  <= {AW{1'b0}};
      occ_q        <= {M{1'b0}};
      gw_q         <= {M{1'b0}};
      trf_q        <= {M{1'b0}};
      fok_q        <= {M{1'b0}};
      prev_occ_q   <= {M{1'b0}};
      prev_fok_q   <= {M{1'b0}};
      bv_q         <= {NBUF{1'b0}};
      bh_q         <= {NBUF{1'b0}};
      cur_q        <= {SW{1'b0}};
      wd_start_q   <= 1'b1;
      stag_start_q <= 1'b0;
      rot_start_q  <= 1'b0;
      rot_stop_q   <= 1'b0;
      cmd_valid_q  <= 1'b0;
      cmd_kind_q   <= `LGPP_CMD_POLL;
      cmd_addr_q   <= {AW{1'b0}};
      cmd_slot_q   <= {SW{1'b0}};
      xfer_valid_q <= 1'b0;
      xfer_l_q     <= {LW{1'b0}};
      xfer_n_q     <= {LW{1'b0}};
      xfer_s_q     <= {AW{1'b0}};
      reroute_q    <= 1'b0;
      undeliv_q    <= 1'b0;
      ret_s_q      <= {AW{1'b0}};
      trouble_q    <= 1'b0;
      trouble_code_q <= 2'h0;
      del_valid_q  <= 1'b0;
      del_mask_q   <= {M{1'b0}};
    end else begin
      wd_start_q   <= 1'b0;
      stag_start_q <= 1'b0;
      rot_start_q  <= 1'b0;
      rot_stop_q   <= 1'b0;
      cmd_valid_q  <= 1'b0;
      xfer_valid_q <= 1'b0;
      reroute_q    <= 1'b0;
      undeliv_q    <= 1'b0;
      trouble_q    <= 1'b0;
      del_valid_q  <= 1'b0;
      if (!init_q) begin
        init_q <= 1'b1;
        self_q <= self_addr_i;
      end
      if (rot_exp)
        rot_done_q <= 1'b1;
      // Incoming frame: buffer if local, else pass to partner
      if (frm_valid_i && frm_ready_o) begin
        if (is_local) begin
          bv_q[free_slot] <= 1'b1;
          bh_q[free_slot] <= 1'b0;
          bs_q[free_slot] <= frm_dst_s_i;
          br_q[free_slot] <= 2'h0;
        end else begin
          xfer_valid_q <= 1'b1;
          xfer_l_q     <= frm_dst_l_i;
          xfer_n_q     <= frm_dst_n_i;
          xfer_s_q     <= frm_dst_s_i;
        end
      end
      case (state_q)
        ST_SEC, ST_STAG: begin
          if (sig_s) begin
            wd_start_q <= 1'b1;
            state_q    <= ST_SEC;
          end else if (wd_exp && state_q == ST_SEC) begin
            stag_start_q <= 1'b1;
            state_q      <= ST_STAG;
          end else if (stag_exp || (grant_i && state_q == ST_SEC)) begin
            primary_q   <= 1'b1;
            rot_start_q <= 1'b1;
            rot_done_q  <= 1'b0;
            full_q      <= 1'b1;
            drain_q     <= grant_i & grant_traffic_i;
            seq_cnt_q   <= 2'h0;
            occ_q       <= {M{1'b0}};
            gw_q        <= {M{1'b0}};
            fok_q       <= {M{1'b0}};
            poll_addr_q <= self_q;
            state_q     <= ST_ADV;
          end
        end
        ST_POLL: begin
          cmd_valid_q <= 1'b1;
          cmd_kind_q  <= `LGPP_CMD_POLL;
          cmd_addr_q  <= poll_addr_q;
          state_q     <= ST_WAIT;
        end
        ST_WAIT: begin
          if (rsp_valid_i) begin
            trf_q[poll_addr_q] <= rsp_present_i & rsp_traffic_i;
            if (full_q) begin
              occ_q[poll_addr_q]  <= rsp_present_i;
              gw_q[poll_addr_q]   <= rsp_present_i & rsp_gateway_i;
              fok_q[poll_addr_q]  <= rsp_present_i & rsp_gateway_i &
                                     rsp_floop_ok_i;
              fl_l_q[poll_addr_q] <= rsp_floop_l_i;
              fl_n_q[poll_addr_q] <= rsp_floop_n_i;
            end
            if (rsp_present_i && rsp_gateway_i && !full_q &&
                (rsp_traffic_i || (rot_done_q && bv_q == {NBUF{1'b0}})))
              state_q <= ST_OFFER;
            else
              state_q <= ST_ADV;
          end
        end
        ST_OFFER: begin
          cmd_valid_q <= 1'b1;
          cmd_kind_q  <= `LGPP_CMD_OFFER;
          cmd_addr_q  <= poll_addr_q;
          state_q     <= ST_OWAIT;
        end
        ST_OWAIT: begin
          if (rsp_valid_i) begin
            if (rsp_ack_i) begin
              primary_q  <= 1'b0;
              rot_stop_q <= 1'b1;
              wd_start_q <= 1'b1;
              state_q    <= ST_SEC;
            end else begin
              state_q <= ST_ADV;
            end
          end
        end
        ST_ADV: begin
          if (fwd_rdy && (!full_q || drain_q)) begin
            cur_q   <= first_idx(fwd_vec);
            state_q <= ST_FWD;
          end else begin
            drain_q     <= 1'b0;
            poll_addr_q <= adv_addr;
            state_q     <= ST_POLL;
            if (adv_wrap) begin
              bh_q <= {NBUF{1'b0}};
              if (full_q) begin
                state_q <= ST_CMP;
              end else if (rot_done_q) begin
                if (seq_cnt_q == SEQ_LAST) begin
                  seq_cnt_q      <= 2'h0;
                  trouble_q      <= |fok_q;
                  trouble_code_q <= `LGPP_TRB_NOHAND;
                end else begin
                  seq_cnt_q <= seq_cnt_q + 2'h1;
                end
              end
            end
          end
        end
        ST_FWD: begin
          cmd_valid_q <= 1'b1;
          cmd_kind_q  <= `LGPP_CMD_FWD;
          cmd_addr_q  <= bs_q[cur_q];
          cmd_slot_q  <= cur_q;
          state_q     <= ST_FWAIT;
        end
        ST_FWAIT: begin
          if (rsp_valid_i) begin
            state_q <= ST_ADV;
            if (rsp_ack_i) begin
              bv_q[cur_q] <= 1'b0;
            end else if (br_q[cur_q] == TRY_LAST) begin
              bv_q[cur_q] <= 1'b0;
              ret_s_q     <= bs_q[cur_q];
              reroute_q   <= rsp_rnr_i;
              undeliv_q   <= ~rsp_rnr_i;
            end else begin
              br_q[cur_q] <= br_q[cur_q] + 2'h1;
              bh_q[cur_q] <= 1'b1;
            end
          end
        end
        ST_CMP: begin
          if (|deleted) begin
            trouble_q      <= 1'b1;
            trouble_code_q <= `LGPP_TRB_OUTAGE;
            del_valid_q    <= 1'b1;
            del_mask_q     <= deleted;
          end
          prev_occ_q <= occ_q;
          prev_fok_q <= fok_q;
          full_q     <= 1'b0;
          state_q    <= ST_ADV;
        end
        default: begin
          state_q <= ST_SEC;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cmd_valid_o    = cmd_valid_q;
  assign cmd_kind_o     = cmd_kind_q;
  assign cmd_addr_o     = cmd_addr_q;
  assign cmd_slot_o     = cmd_slot_q;
  assign xfer_valid_o   = xfer_valid_q;
  assign xfer_dst_l_o   = xfer_l_q;
  assign xfer_dst_n_o   = xfer_n_q;
  assign xfer_dst_s_o   = xfer_s_q;
  assign reroute_o      = reroute_q;
  assign undeliv_o      = undeliv_q;
  assign ret_dst_s_o    = ret_s_q;
  assign trouble_o      = trouble_q;
  assign trouble_code_o = trouble_code_q;
  assign del_valid_o    = del_valid_q;
  assign del_mask_o     = del_mask_q;
  assign primary_o      = primary_q;
endmodule // lgpp_core

// >>> core/lgpp_map.vh
// Constants for the loop gateway primary poller: sizes, timing, codes.
// Assumes a single 125 MHz station clock; included by lgpp_core, lgpp_asserts and the bench.
`ifndef LGPP_MAP_VH
`define LGPP_MAP_VH

// Clock rate
`define LGPP_CLK_HZ       125000000
`define LGPP_CLK_MHZ      125

// Loop geometry and buffering
`define LGPP_MAX_STATIONS 32
`define LGPP_ADDR_W       5
`define LGPP_COORD_W      8
`define LGPP_GW_BUFS      7
`define LGPP_STA_BUFS     3
`define LGPP_INFO_BYTES   1000
`define LGPP_SLOT_W       3

// Retry and sequence limits
`define LGPP_TRY_LIMIT    2'h3
`define LGPP_SEQ_LIMIT    2'h3

// Times in their own units
`define LGPP_ROT_TIME_S   60
`define LGPP_WD_TIME_NS   1200
`define LGPP_PROP_TIME_NS 1000
`define LGPP_E2E_TIME_US  1000

// Cycle counts derived from the times (least times round up)
`define LGPP_ROT_CYC  (64'd1 * `LGPP_ROT_TIME_S * `LGPP_CLK_HZ)
`define LGPP_WD_CYC   ((`LGPP_WD_TIME_NS * `LGPP_CLK_MHZ + 999) / 1000)
`define LGPP_PROP_CYC ((`LGPP_PROP_TIME_NS * `LGPP_CLK_MHZ + 999) / 1000)
`define LGPP_E2E_CYC  (`LGPP_E2E_TIME_US * `LGPP_CLK_MHZ)

// Command kinds on the loop command port
`define LGPP_CMD_POLL     2'h0
`define LGPP_CMD_OFFER    2'h1
`define LGPP_CMD_FWD      2'h2

// Trouble message codes
`define LGPP_TRB_NOHAND   2'h1
`define LGPP_TRB_OUTAGE   2'h2

`endif

// >>> core/lgpp_sync.v
// Two-stage synchroniser for a level arriving from a pin.
// Assumes the input may change at any time relative to sys_clk_i.
`timescale 1ns/1ns
module lgpp_sync (
  input  wire sys_clk_i,
  input  wire rst_n_i,
  input  wire async_i,
  output wire sync_o
);
  reg meta_q;
  reg sync_q;

  // First stage feeds only the second stage
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule // lgpp_sync

// >>> core/lgpp_timer.v
// One-shot down counter with load, start, stop and an expiry pulse.
// Assumes start and stop are single-cycle pulses from the same clock.
`timescale 1ns/1ns
module lgpp_timer #(
  parameter W = 34
) (
  input  wire         sys_clk_i,
  input  wire         rst_n_i,
  input  wire         start_i,
  input  wire         stop_i,
  input  wire [W-1:0] load_i,
  output wire         expire_o
);
  reg [W-1:0] cnt_q;
  reg         run_q;
  reg         exp_q;

  // Stop beats start; expiry pulses once when the count runs out
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= {W{1'b0}};
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      exp_q <= 1'b0;
      if (stop_i) begin
        run_q <= 1'b0;
      end else if (start_i) begin
        cnt_q <= load_i;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == {W{1'b0}}) begin
          run_q <= 1'b0;
          exp_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

  assign expire_o = exp_q;
endmodule // lgpp_timer

// >>> verification/lgpp_asserts.sv
// Checker for lgpp_core: command order, frames, election, e2e wait.
// Sees only core ports; bound to every lgpp_core below.
`timescale 1ns/1ns
`include "lgpp_map.vh"
module lgpp_asserts #(
  parameter        AW      = 5,
  parameter        LW      = 8,
  parameter [31:0] E2E_CYC = 500
) (
  input wire          sys_clk_i,
  input wire          rst_n_i,
  input wire [AW-1:0] self_addr_i,
  input wire [LW-1:0] loop_l_i,
  input wire [LW-1:0] loop_n_i,
  input wire          cmd_valid_o,
  input wire [1:0]    cmd_kind_o,
  input wire [AW-1:0] cmd_addr_o,
  input wire          rsp_valid_i,
  input wire          rsp_ack_i,
  input wire          frm_valid_i,
  input wire          frm_ready_o,
  input wire [LW-1:0] frm_dst_l_i,
  input wire [LW-1:0] frm_dst_n_i,
  input wire          xfer_valid_o,
  input wire [LW-1:0] xfer_dst_l_o,
  input wire [LW-1:0] xfer_dst_n_o,
  input wire          msg_sent_i,
  input wire          not_delivered_o,
  input wire          primary_o
);
  reg  [31:0] e2e_cnt_q;
  wire        take_w = frm_valid_i & frm_ready_o;
  wire        home_w = {frm_dst_l_i, frm_dst_n_i} == {loop_l_i, loop_n_i};
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Cycles since the last message went out
  always @(posedge sys_clk_i) begin
    e2e_cnt_q <= (!rst_n_i) ? 32'h0 : msg_sent_i ? 32'h1 : e2e_cnt_q + 32'h1;
  end
  //////////////////////////////////////////////////////////////////////////
  property p_cmd_wait;
    cmd_valid_o |=> !cmd_valid_o until rsp_valid_i;
  endproperty
  a_cmd_wait: assert property (p_cmd_wait)
    else $error("second command before answer");
  property p_cmd_prim;
    cmd_valid_o |-> primary_o;
  endproperty
  a_cmd_prim: assert property (p_cmd_prim)
    else $error("command while secondary");
  property p_first_poll;
    $rose(primary_o) |-> ##[1:3] (cmd_valid_o && cmd_kind_o == `LGPP_CMD_POLL
      && cmd_addr_o == self_addr_i + 1'b1);
  endproperty
  a_first_poll: assert property (p_first_poll)
    else $error("first poll missing or wrong address");
  property p_next_cmd;
    rsp_valid_i && primary_o && !(cmd_kind_o == `LGPP_CMD_OFFER && rsp_ack_i)
      |-> ##[1:5] cmd_valid_o;
  endproperty
  a_next_cmd: assert property (p_next_cmd)
    else $error("polling stalled after answer");
  property p_hand;
    rsp_valid_i && rsp_ack_i && cmd_kind_o == `LGPP_CMD_OFFER
      |-> ##[1:3] !primary_o;
  endproperty
  a_hand: assert property (p_hand)
    else $error("accepted offer kept primary");
  property p_xfer;
    take_w && !home_w |=> xfer_valid_o && xfer_dst_l_o == $past(frm_dst_l_i)
      && xfer_dst_n_o == $past(frm_dst_n_i);
  endproperty
  a_xfer: assert property (p_xfer)
    else $error("foreign frame not passed on");
  property p_local;
    take_w && home_w |=> !xfer_valid_o;
  endproperty
  a_local: assert property (p_local)
    else $error("local frame sent to partner");
  property p_e2e;
    not_delivered_o |-> e2e_cnt_q inside {[E2E_CYC + 1 : E2E_CYC + 3]};
  endproperty
  a_e2e: assert property (p_e2e)
    else $error("end-to-end timeout at wrong time");
  c_prim: cover property ($rose(primary_o));
  c_xfer: cover property (xfer_valid_o);
  c_nd: cover property (not_delivered_o);
endmodule // lgpp_asserts

bind lgpp_core lgpp_asserts #(.AW(AW), .LW(LW), .E2E_CYC(E2E_CYC))
  i_lgpp_asserts (.*);

// >>> verification/lgpp_loop_model.sv
// Stations on the loop answering the primary's commands.
// Assumes one command outstanding; answers after 2 or 6 cycles.
`timescale 1ns/1ns
module lgpp_loop_model (
  input  wire        sys_clk_i,
  input  wire        cmd_valid_i,
  input  wire [4:0]  cmd_addr_i,
  input  wire [31:0] occ_i,
  input  wire [31:0] gw_i,
  input  wire        slow_i,
  input  wire        full_i,
  output reg         rsp_valid_o,
  output reg         rsp_present_o,
  output reg         rsp_gateway_o,
  output reg         rsp_traffic_o,
  output reg         rsp_ack_o,
  output reg         rsp_rnr_o,
  output reg  [7:0]  rsp_floop_l_o,
  output reg  [7:0]  rsp_floop_n_o,
  output reg         rsp_floop_ok_o
);
  reg [3:0] wait_q = 4'h0;
  reg [7:0] tog_q  = 8'h00;
  initial {rsp_valid_o, rsp_ack_o, rsp_rnr_o, rsp_present_o} = 4'h0;
  // Answer delay, then status; lines churn between answers
  always @(posedge sys_clk_i) begin
    tog_q       <= tog_q + 8'h01;
    rsp_valid_o <= (wait_q == 4'h1);
    if (cmd_valid_i === 1'b1) begin
      wait_q <= slow_i ? 4'h6 : 4'h2;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end
    if (wait_q == 4'h1) begin
      rsp_present_o  <= occ_i[cmd_addr_i];
      rsp_gateway_o  <= gw_i[cmd_addr_i];
      rsp_traffic_o  <= 1'b0;
      rsp_ack_o      <= occ_i[cmd_addr_i] & ~full_i;
      rsp_rnr_o      <= occ_i[cmd_addr_i] & full_i;
      rsp_floop_l_o  <= 8'h05;
      rsp_floop_n_o  <= 8'h03;
      rsp_floop_ok_o <= gw_i[cmd_addr_i];
    end else begin
      {rsp_present_o, rsp_gateway_o, rsp_traffic_o, rsp_ack_o, rsp_rnr_o,
        rsp_floop_ok_o} <= tog_q[5:0];
      rsp_floop_l_o  <= ~tog_q;
      rsp_floop_n_o  <= tog_q;
    end
  end
endmodule // lgpp_loop_model

// >>> verification/lgpp_core_tb.sv
// Bench for lgpp_core: election, polling, frames, e2e wait, handover.
// Assumes the loop model answers every command; timers shortened.
`timescale 1ns/1ns
`include "lgpp_map.vh"
module lgpp_core_tb;
  localparam integer E2E = 500;
  reg        sys_clk_i = 1'b0;
  reg        rst_n_i   = 1'b0;
  reg        sig_i     = 1'b1;
  reg        frm_v     = 1'b0;
  reg  [7:0] dst_l     = 8'h02;
  reg  [4:0] dst_s     = 5'h03;
  reg        sent      = 1'b0;
  reg        ack       = 1'b0;
  reg        slow      = 1'b0;
  reg        full      = 1'b0;
  reg        grant     = 1'b0;
  reg  [7:0] dst_n     = 8'h03;
  wire       cv, rv, pr, gw, tr, ak, rn, fok, rdy, xv, nd, prim, rr;
  wire [1:0] ck;
  wire [4:0] ca;
  wire [7:0] fl, fn, xl, xn;
  integer    err_count   = 0;
  integer    checks_done = 0;
  reg  [6:0] cmd_q [$];
  lgpp_core #(.ROT_CYC(64'd3000), .PROP_CYC(32'd4), .E2E_CYC(E2E)) i_lgpp_core (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .self_addr_i(5'h01),
    .loop_l_i(8'h02), .loop_n_i(8'h03), .loop_signal_i(sig_i),
    .cmd_valid_o(cv), .cmd_kind_o(ck), .cmd_addr_o(ca), .cmd_slot_o(),
    .rsp_valid_i(rv), .rsp_present_i(pr), .rsp_gateway_i(gw),
    .rsp_traffic_i(tr), .rsp_ack_i(ak), .rsp_rnr_i(rn), .rsp_floop_l_i(fl),
    .rsp_floop_n_i(fn), .rsp_floop_ok_i(fok), .grant_i(grant),
    .grant_traffic_i(grant), .frm_valid_i(frm_v), .frm_ready_o(rdy),
    .frm_dst_l_i(dst_l), .frm_dst_n_i(dst_n), .frm_dst_s_i(dst_s),
    .xfer_valid_o(xv), .xfer_dst_l_o(xl), .xfer_dst_n_o(xn),
    .xfer_dst_s_o(), .reroute_o(rr), .undeliv_o(), .ret_dst_s_o(),
    .msg_sent_i(sent), .e2e_ack_i(ack), .not_delivered_o(nd), .trouble_o(),
    .trouble_code_o(), .del_valid_o(), .del_mask_o(), .primary_o(prim));
  lgpp_loop_model i_lgpp_loop_model (
    .sys_clk_i(sys_clk_i), .cmd_valid_i(cv), .cmd_addr_i(ca),
    .occ_i(32'h48), .gw_i(32'h40), .slow_i(slow), .full_i(full),
    .rsp_valid_o(rv), .rsp_present_o(pr), .rsp_gateway_o(gw),
    .rsp_traffic_o(tr), .rsp_ack_o(ak), .rsp_rnr_o(rn),
    .rsp_floop_l_o(fl), .rsp_floop_n_o(fn), .rsp_floop_ok_o(fok));
  //////////////////////////////////////////////////////////////////////////
  // Clock, command log, watchdog
  initial forever #4 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (cv === 1'b1) cmd_q.push_back({ck, ca});
  initial begin
    #400000;
    err_count = err_count + 1;
    print_verdict;
  end
  task check(input [31:0] seen, input [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task find_cmd(input [6:0] v, input integer from, output integer j);
    j = -1;
    for (int k = 0; k < 6000 && j < 0; k++) begin
      @(negedge sys_clk_i);
      for (int i = from; i < cmd_q.size(); i++) if (cmd_q[i] === v) j = i;
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Quiet while the loop is alive, then elected in time
  task t_elect;
    integer k;
    repeat (300) @(negedge sys_clk_i);
    check(prim, 0);
    sig_i <= 1'b0;
    for (k = 0; k < 400 && prim !== 1'b1; k++) @(negedge sys_clk_i);
    check(k >= 150 && k <= 165, 1);
    $display("elect done");
  endtask
  // Full poll 2..31,0 then listed stations only
  task t_polls;
    integer j;
    slow <= 1'b1;
    find_cmd(7'h06, 34, j);
    for (int i = 0; i < 31; i++) check(cmd_q[i], (i + 2) % 32);
    for (int i = 31; i < 35; i++) check(cmd_q[i], i % 2 ? 3 : 6);
    $display("polls done");
  endtask
  // Foreign frame to partner, local frame forwarded between polls
  task send_frm(input [7:0] l, input [7:0] n);
    @(posedge sys_clk_i);
    dst_l <= l;
    dst_n <= n;
    frm_v <= 1'b1;
    do @(posedge sys_clk_i); while (rdy !== 1'b1);
    frm_v <= 1'b0;
    @(negedge sys_clk_i);
  endtask
  task t_frames;
    integer j;
    integer n;
    send_frm(8'h04, 8'h03);
    check(xv, 1);
    check(xl, 8'h04);
    send_frm(8'h02, 8'h05);
    check(xv, 1);
    n = cmd_q.size();
    send_frm(8'h02, 8'h03);
    check(xv, 0);
    find_cmd(7'h43, n, j);
    check(j >= 0, 1);
    repeat (20) @(negedge sys_clk_i);
    check(cmd_q[j + 1][6:5], `LGPP_CMD_POLL);
    $display("frames done");
  endtask
  // Full station refuses; frame rerouted after three tries
  task t_rnr;
    integer k;
    full <= 1'b1;
    send_frm(8'h02, 8'h03);
    for (k = 0; k < 400 && rr !== 1'b1; k++) @(negedge sys_clk_i);
    check(rr, 1);
    full <= 1'b0;
    $display("rnr done");
  endtask
  // End-to-end wait: timeout without answer, silence with one
  task t_e2e(input with_ack);
    integer k;
    sent <= 1'b1;
    @(posedge sys_clk_i);
    sent <= 1'b0;
    ack  <= with_ack;
    @(posedge sys_clk_i);
    ack  <= 1'b0;
    for (k = 2; k < E2E + 20 && nd !== 1'b1; k++) @(negedge sys_clk_i);
    check(k >= E2E && k <= E2E + 4, !with_ack);
    $display("e2e done");
  endtask
  // Rotation expiry hands primary to gateway 6; a grant brings it back
  task t_hand;
    integer j;
    find_cmd(7'h26, 0, j);
    check(j >= 0, 1);
    repeat (12) @(negedge sys_clk_i);
    check(prim, 0);
    grant <= 1'b1;
    @(posedge sys_clk_i);
    grant <= 1'b0;
    repeat (3) @(negedge sys_clk_i);
    check(prim, 1);
    $display("handover done");
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_elect;
    t_polls;
    t_frames;
    t_rnr;
    t_e2e(1'b0);
    t_e2e(1'b1);
    t_hand;
    print_verdict;
  end
endmodule // lgpp_core_tb
